// ==== core/ddr_storage_packing_if.sv ====
// Word FIFO and DDR packing controller for the four-chip x16 arrangement
`timescale 1ns/1ns
`default_nettype none

module word_fifo #(
  parameter int W = 48,
  parameter int D = 16
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  assign o_in_ready  = (cnt_r != (AW+1)'(D));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rp_r];
  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;

  always_comb begin
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end
endmodule

module ddr_storage_packing_if
  import ddr_pack_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  input  wire logic [2:0]        i_memory_config_select,
  input  wire logic [1:0]        i_memory_type_select,
  input  wire logic              i_wr_valid,
  input  wire logic [WORD_W-1:0] i_wr_data,
  output logic                   o_wr_ready,
  output logic                   o_rd_valid,
  output logic [WORD_W-1:0]      o_rd_data,
  input  wire logic              i_rd_ready,
  output logic                   o_full,
  output logic                   o_empty,
  output logic                   o_ecc_on,
  output logic                   o_cfg_err,
  output logic                   o_corrected,
  output mem_cmd_s               o_mem_cmd,
  output logic [BEAT_W-1:0]      o_mem_dq,
  output logic                   o_mem_dq_oe_n,
  input  wire logic [BEAT_W-1:0] i_mem_dq,
  output logic [LANES-1:0]       o_mem_dqs,
  output logic                   o_mem_dqs_oe_n
);
  localparam int GW = 4 * WORD_W;

  // Hamming position of each data bit skips powers of two
  function automatic logic [SYN_W-1:0] check_bits(input logic [63:0] d);
    logic [SYN_W-1:0] s;
    logic [6:0]       p;
    s = '0;
    p = 7'h02;
    for (int i = 0; i < BEAT_W; i++) begin
      p = p + 7'h01;
      if ((p & (p - 7'h01)) == 7'h00) p = p + 7'h01;
      for (int j = 0; j < 7; j++) if (p[j]) s[j] = s[j] ^ d[i];
    end
    s[7] = ^d;
    return s;
  endfunction

  function automatic logic [63:0] fix(input logic [63:0] d,
                                      input logic [6:0]  syn);
    logic [63:0] r;
    logic [6:0]  p;
    r = d;
    p = 7'h02;
    for (int i = 0; i < BEAT_W; i++) begin
      p = p + 7'h01;
      if ((p & (p - 7'h01)) == 7'h00) p = p + 7'h01;
      if (syn == p) r[i] = ~r[i];
    end
    return r;
  endfunction

  logic [2:0]        sel_s1_r, sel_s2_r;
  logic [1:0]        typ_s1_r, typ_s2_r;
  logic [BEAT_W-1:0] dq_s1_r, dq_s2_r;
  logic              cfg_done_r, ecc_r, err_r;
  logic              f_valid, f_ready;
  logic [WORD_W-1:0] f_data;

  word_fifo #(.W(WORD_W), .D(FIFO_D)) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (i_wr_valid),
    .o_in_ready  (o_wr_ready),
    .i_in_data   (i_wr_data),
    .o_out_valid (f_valid),
    .i_out_ready (f_ready),
    .o_out_data  (f_data)
  );

  // Straps and read data come from pins, so two stages first
  // Strap stages run through reset so the mode is settled at release
  always_ff @(posedge i_sys_clk) begin
    sel_s1_r <= i_memory_config_select;
    sel_s2_r <= sel_s1_r;
    typ_s1_r <= i_memory_type_select;
    typ_s2_r <= typ_s1_r;
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= i_mem_dq;
      dq_s2_r <= dq_s1_r;
    end
  end

  ctl_state_e        st_r, st_nxt;
  logic [GW-1:0]     g_r, g_nxt, bd_r, bd_nxt, rb_r, rb_nxt;
  logic [2:0]        gcnt_r, gcnt_nxt, rbcnt_r, rbcnt_nxt;
  logic [1:0]        beat_r, beat_nxt;
  logic [2:0]        lat_r, lat_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt, limit;
  logic [14:0]       wrow_r, wrow_nxt, rrow_r, rrow_nxt;
  logic [8:0]        wcol_r, wcol_nxt, rcol_r, rcol_nxt;
  mem_cmd_s          cmd_r, cmd_nxt;
  logic [BEAT_W-1:0] dq_r, dq_nxt;
  logic              oe_n_r, oe_n_nxt, dqs_r, dqs_nxt, cor_r, cor_nxt;
  logic              cfg_done_nxt, ecc_nxt, err_nxt;
  logic [2:0]        bw;
  logic [63:0]       b0, b1, b2, c0, c1;
  logic [SYN_W-1:0]  k0, k1;
  logic              pop, wr_go, rd_go;

  assign bw    = ecc_r ? WORDS_ON : WORDS_OFF;
  assign limit = ecc_r ? LIMIT_ON : LIMIT_OFF;
  assign f_ready = cfg_done_r && !err_r && (gcnt_r < bw);
  assign pop   = f_valid && f_ready;
  assign wr_go = (gcnt_r == bw) && (cnt_r + CNT_W'(bw) <= limit);
  assign rd_go = (cnt_r >= CNT_W'(bw)) && (rbcnt_r == 3'h0);
  assign b0 = bd_r[63:0];
  assign b1 = bd_r[127:64];
  assign b2 = bd_r[191:128];
  assign k0 = check_bits(b0);
  assign k1 = check_bits(b1);
  assign c0 = fix(b0, k0[6:0] ^ b2[6:0]);
  assign c1 = fix(b1, k1[6:0] ^ b2[14:8]);

  always_comb begin
    cfg_done_nxt = 1'b1;
    ecc_nxt = ecc_r;
    err_nxt = err_r;
    // Mode caught once after reset release
    if (!cfg_done_r) begin
      ecc_nxt = (sel_s2_r == CFG_ECC_ON);
      err_nxt = !((sel_s2_r == CFG_ECC_ON || sel_s2_r == CFG_ECC_OFF)
                  && typ_s2_r == TYPE_X16);
    end
    st_nxt = st_r;
    g_nxt = g_r;
    gcnt_nxt = gcnt_r;
    bd_nxt = bd_r;
    rb_nxt = rb_r;
    rbcnt_nxt = rbcnt_r;
    beat_nxt = beat_r;
    lat_nxt = lat_r;
    cnt_nxt = cnt_r;
    wrow_nxt = wrow_r;
    wcol_nxt = wcol_r;
    rrow_nxt = rrow_r;
    rcol_nxt = rcol_r;
    cmd_nxt = CMD_NOP;
    dq_nxt = dq_r;
    oe_n_nxt = 1'b1;
    dqs_nxt = 1'b0;
    cor_nxt = 1'b0;
    if (pop) begin
      g_nxt[gcnt_r*WORD_W +: WORD_W] = f_data;
      gcnt_nxt = gcnt_r + 3'h1;
    end
    if (o_rd_valid && i_rd_ready) begin
      rb_nxt = rb_r >> WORD_W;
      rbcnt_nxt = rbcnt_r - 3'h1;
    end
    unique case (st_r)
      ST_IDLE: begin
        if (wr_go) begin
          st_nxt = ST_WACT;
          gcnt_nxt = 3'h0;
          cnt_nxt = cnt_r + CNT_W'(bw);
          // Dense pack, four words over three columns
          bd_nxt = g_r;
          // Check bits over each 64-bit data beat
          if (ecc_r) begin
            // Third beat holds syndromes, rest zero
            bd_nxt = {64'h0, 16'h0, g_r[95:48], 16'h0, g_r[47:0]};
            bd_nxt[135:128] = check_bits({16'h0, g_r[47:0]});
            bd_nxt[143:136] = check_bits({16'h0, g_r[95:48]});
          end
          cmd_nxt = '{1'b0, 1'b1, 1'b1, wrow_r[1:0], wrow_r[14:2]};
        end else if (rd_go) begin
          st_nxt = ST_RACT;
          cnt_nxt = cnt_r - CNT_W'(bw);
          cmd_nxt = '{1'b0, 1'b1, 1'b1, rrow_r[1:0], rrow_r[14:2]};
        end
      end
      ST_WACT: begin
        st_nxt = ST_WCMD;
        // One command and address for all chips
        cmd_nxt = '{1'b1, 1'b0, 1'b0, wrow_r[1:0],
                    {2'h0, AUTO_PRE, 1'b0, wcol_r}};
        dq_nxt = b0;
        oe_n_nxt = 1'b0;
        dqs_nxt = 1'b1;
        beat_nxt = 2'h1;
      end
      ST_WCMD, ST_WBEAT: begin
        // Second beat then the third, which is data or, with correction on, syndromes
        dq_nxt = (beat_r == 2'h1) ? b1 : b2;
        oe_n_nxt = 1'b0;
        dqs_nxt = !dqs_r;
        beat_nxt = beat_r + 2'h1;
        st_nxt = ST_WBEAT;
        if (beat_r == BEATS - 2'h1) begin
          st_nxt = ST_IDLE;
          // Columns past the used span stay empty
          wcol_nxt = wcol_r + 9'(BEATS);
          if (wcol_nxt == COLS_USED) begin
            wcol_nxt = 9'h000;
            wrow_nxt = wrow_r + 15'h0001;
          end
        end
      end
      ST_RACT: begin
        st_nxt = ST_RCMD;
        cmd_nxt = '{1'b1, 1'b0, 1'b1, rrow_r[1:0],
                    {2'h0, AUTO_PRE, 1'b0, rcol_r}};
        lat_nxt = 3'h0;
        beat_nxt = 2'h0;
      end
      ST_RCMD: begin
        lat_nxt = lat_r + 3'h1;
        if (lat_r == RD_LAT - 3'h1) st_nxt = ST_RCAP;
      end
      ST_RCAP: begin
        beat_nxt = beat_r + 2'h1;
        // Index 3 lies past the buffer, so only beats 0..2 are stored
        if (beat_r != BEATS) begin
          bd_nxt[beat_r*BEAT_W +: BEAT_W] = dq_s2_r;
        end else begin
          st_nxt = ST_IDLE;
          rb_nxt = bd_r;
          rbcnt_nxt = bw;
          if (ecc_r) begin
            rb_nxt = {96'h0, c1[47:0], c0[47:0]};
            cor_nxt = (c0 != b0) || (c1 != b1);
          end
          rcol_nxt = rcol_r + 9'(BEATS);
          if (rcol_nxt == COLS_USED) begin
            rcol_nxt = 9'h000;
            rrow_nxt = rrow_r + 15'h0001;
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_done_r <= 1'b0;
      ecc_r <= 1'b0;
      err_r <= 1'b0;
      st_r <= ST_IDLE;
      g_r <= '0;
      gcnt_r <= 3'h0;
      bd_r <= '0;
      rb_r <= '0;
      rbcnt_r <= 3'h0;
      beat_r <= 2'h0;
      lat_r <= 3'h0;
      cnt_r <= '0;
      wrow_r <= 15'h0000;
      wcol_r <= 9'h000;
      rrow_r <= 15'h0000;
      rcol_r <= 9'h000;
      cmd_r <= CMD_NOP;
      dq_r <= '0;
      oe_n_r <= 1'b1;
      dqs_r <= 1'b0;
      cor_r <= 1'b0;
    end else begin
      cfg_done_r <= cfg_done_nxt;
      ecc_r <= ecc_nxt;
      err_r <= err_nxt;
      st_r <= st_nxt;
      g_r <= g_nxt;
      gcnt_r <= gcnt_nxt;
      bd_r <= bd_nxt;
      rb_r <= rb_nxt;
      rbcnt_r <= rbcnt_nxt;
      beat_r <= beat_nxt;
      lat_r <= lat_nxt;
      cnt_r <= cnt_nxt;
      wrow_r <= wrow_nxt;
      wcol_r <= wcol_nxt;
      rrow_r <= rrow_nxt;
      rcol_r <= rcol_nxt;
      cmd_r <= cmd_nxt;
      dq_r <= dq_nxt;
      oe_n_r <= oe_n_nxt;
      dqs_r <= dqs_nxt;
      cor_r <= cor_nxt;
    end
  end

  // Per-chip data slices and per-lane strobes
  for (genvar c = 0; c < CHIPS; c++) begin : g_chip
    assign o_mem_dq[c*SLICE_W +: SLICE_W] = dq_r[c*SLICE_W +: SLICE_W];
    assign o_mem_dqs[2*c]   = dqs_r;
    assign o_mem_dqs[2*c+1] = dqs_r;
  end

  assign o_mem_cmd      = cmd_r;
  assign o_mem_dq_oe_n  = oe_n_r;
  assign o_mem_dqs_oe_n = oe_n_r;
  assign o_rd_valid     = (rbcnt_r != 3'h0);
  assign o_rd_data      = rb_r[WORD_W-1:0];
  assign o_full         = (cnt_r + CNT_W'(bw) > limit);
  assign o_empty        = (cnt_r == '0);
  assign o_ecc_on       = ecc_r;
  assign o_cfg_err      = err_r;
  assign o_corrected    = cor_r;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_write_cmd;
    !o_mem_cmd.cas_n && !o_mem_cmd.we_n;
  endsequence
  sequence s_three_beats;
    !o_mem_dq_oe_n [*3] ##1 o_mem_dq_oe_n;
  endsequence

  a_full_burst_len: assert property (s_write_cmd |-> s_three_beats)
    else $error("write burst not three beats");
  a_syn_beat: assert property ((s_write_cmd and ecc_r) |->
    ##2 o_mem_dq[63:16] == 48'h0)
    else $error("syndrome beat upper bits not zero");
  a_syn_value: assert property ((s_write_cmd and ecc_r) |->
    ##2 o_mem_dq[7:0] == check_bits($past(o_mem_dq, 2)))
    else $error("syndrome mismatch");
  a_data_pad: assert property ((s_write_cmd and ecc_r) |->
    o_mem_dq[63:48] == 16'h0 ##1 o_mem_dq[63:48] == 16'h0)
    else $error("ecc data beat not padded");
  a_depth_limit: assert property (cnt_r <= limit)
    else $error("occupancy above limit");
  a_col_skip: assert property (wcol_r < COLS_USED && rcol_r < COLS_USED)
    else $error("unused column addressed");
  a_strobe_lanes: assert property (!o_mem_dqs_oe_n |->
    o_mem_dqs == {LANES{o_mem_dqs[0]}} ##1 $changed(o_mem_dqs) ||
    o_mem_dqs_oe_n)
    else $error("strobes not shared or not toggling");
  a_cfg_mode: assert property ($rose(cfg_done_r) |->
    ecc_r == ($past(sel_s2_r) == CFG_ECC_ON))
    else $error("correction mode wrong");
  a_fix_pass: assert property (st_r == ST_RCAP && beat_r == BEATS &&
    ecc_r && k0[6:0] == b2[6:0] |=> rb_r[47:0] == $past(b0[47:0]))
    else $error("clean word altered");
endmodule

`default_nettype wire

// ==== pkg/ddr_pack_pkg.sv ====
// Constants, types and layouts shared by the DDR storage packing block
package ddr_pack_pkg;
  localparam int WORD_W  = 48;
  localparam int BEAT_W  = 64;
  localparam int CHIPS   = 4;
  localparam int SLICE_W = 16;
  localparam int LANES   = 8;
  localparam int SYN_W   = 8;
  localparam int FIFO_D  = 16;
  localparam int CNT_W   = 25;
  localparam logic [2:0] CFG_ECC_OFF = 3'h7;
  localparam logic [2:0] CFG_ECC_ON  = 3'h5;
  localparam logic [1:0] TYPE_X16    = 2'h3;
  localparam logic [2:0] WORDS_OFF   = 3'h4;
  localparam logic [2:0] WORDS_ON    = 3'h2;
  localparam logic [1:0] BEATS       = 2'h3;
  localparam logic [8:0] COLS_USED   = 9'h1F8;
  localparam logic [2:0] RD_LAT      = 3'h4;
  localparam logic       AUTO_PRE    = 1'b1;
  localparam int unsigned MBIT       = 1024 * 1024;
  localparam logic [CNT_W-1:0] LIMIT_OFF = CNT_W'(1008 * MBIT / WORD_W);
  localparam logic [CNT_W-1:0] LIMIT_ON  = CNT_W'(576 * MBIT / WORD_W);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_WACT  = 3'h1,
    ST_WCMD  = 3'h3,
    ST_WBEAT = 3'h2,
    ST_RCAP  = 3'h6,
    ST_RCMD  = 3'h7,
    ST_RACT  = 3'h5
  } ctl_state_e;

  typedef struct packed {
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [12:0] addr;
  } mem_cmd_s;

  localparam mem_cmd_s CMD_NOP = '{1'b1, 1'b1, 1'b1, 2'h0, 13'h0000};
endpackage

// ==== tb/ddr_mem_model.sv ====
// Behavioural model of four x16 DDR memories seen as one 64-bit bus
`timescale 1ns/1ns
`default_nettype none
module ddr_mem_model
  import ddr_pack_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire mem_cmd_s          i_mem_cmd,
  input  wire logic [BEAT_W-1:0] i_mem_dq,
  input  wire logic              i_mem_dq_oe_n,
  input  wire logic [LANES-1:0]  i_mem_dqs,
  input  wire logic              i_flip,
  output logic [BEAT_W-1:0]      o_mem_dq,
  output logic [191:0]           o_last_burst,
  output int                     o_bursts,
  output int                     o_errs
);
  logic [191:0] mem [logic [23:0]];
  logic [191:0] rd_r;
  logic [14:0]  row_r;
  logic [23:0]  wkey_r;
  logic [23:0]  rkey_r;
  int           wb = -1;
  int           rc = -1;
  initial begin
    o_mem_dq = '0;
    o_last_burst = '0;
    o_bursts = 0;
    o_errs = 0;
  end
  always @(posedge i_sys_clk) begin
    if (rc >= 0) rc++;
    // command and address lines are shared by all chips
    if (i_mem_cmd.ras_n === 1'b0) begin
      row_r = {i_mem_cmd.addr, i_mem_cmd.ba};
    end else if (i_mem_cmd.cas_n === 1'b0 && i_mem_cmd.we_n === 1'b0) begin
      wkey_r = {row_r, i_mem_cmd.addr[8:0]};
      wb = 0;
    end else if (i_mem_cmd.cas_n === 1'b0) begin
      rkey_r = {row_r, i_mem_cmd.addr[8:0]};
      rc = 0;
    end
    // three whole beats, strobes on every lane
    if (wb >= 0) begin
      if (i_mem_dq_oe_n !== 1'b0 || i_mem_dqs !== {LANES{wb != 1}}) begin
        o_errs++;
      end
      o_last_burst[wb*BEAT_W +: BEAT_W] = i_mem_dq;
      wb++;
      if (wb == 3) begin
        mem[wkey_r] = o_last_burst;
        o_bursts++;
        wb = -1;
      end
    end
    // Beats follow two cycles after the read command leaves the block
    if (rc == 1) begin
      rd_r = mem.exists(rkey_r) ? mem[rkey_r] : '1;
      rd_r[5] = rd_r[5] ^ i_flip;
    end
    // Idle bus keeps changing so a stale beat is never mistaken for data
    if (rc >= 1 && rc <= 3) begin
      o_mem_dq <= #1 rd_r[(rc-1)*BEAT_W +: BEAT_W];
    end else begin
      o_mem_dq <= #1 ~o_mem_dq;
    end
    if (rc == 3) rc = -1;
  end
endmodule
`default_nettype wire

// ==== tb/ddr_storage_packing_if_tb_top.sv ====
// Self-checking bench for the DDR storage packing block
`timescale 1ns/1ns
`default_nettype none
module ddr_storage_packing_if_tb_top;
  import ddr_pack_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [2:0]        mcs = 3'h7;
  logic [1:0]        mts = 2'h3;
  logic              wv = 1'b0;
  logic [WORD_W-1:0] wd = '0;
  logic              rr = 1'b0;
  logic              flip = 1'b0;
  logic              wr_rdy, rd_v, full, empty, ecc, cerr, corr, oe_n;
  logic              dqs_oe_n;
  logic [WORD_W-1:0] rd_d;
  mem_cmd_s          cmd;
  logic [BEAT_W-1:0] dq_o, dq_i;
  logic [LANES-1:0]  dqs;
  logic [191:0]      last;
  int                bursts, merrs, ncorr, fails, total_checks;

  // Port clock at 25 MHz, well inside the port limit
  always #20 clk = ~clk;
  always @(posedge clk) if (corr === 1'b1) ncorr++;

  ddr_storage_packing_if dut (
    .i_sys_clk(clk), .i_sys_rst(rst),
    .i_memory_config_select(mcs), .i_memory_type_select(mts),
    .i_wr_valid(wv), .i_wr_data(wd), .o_wr_ready(wr_rdy),
    .o_rd_valid(rd_v), .o_rd_data(rd_d), .i_rd_ready(rr),
    .o_full(full), .o_empty(empty), .o_ecc_on(ecc), .o_cfg_err(cerr),
    .o_corrected(corr), .o_mem_cmd(cmd), .o_mem_dq(dq_o),
    .o_mem_dq_oe_n(oe_n), .i_mem_dq(dq_i), .o_mem_dqs(dqs),
    .o_mem_dqs_oe_n(dqs_oe_n));
  ddr_mem_model mem (
    .i_sys_clk(clk), .i_mem_cmd(cmd), .i_mem_dq(dq_o),
    .i_mem_dq_oe_n(oe_n), .i_mem_dqs(dqs), .i_flip(flip),
    .o_mem_dq(dq_i), .o_last_burst(last), .o_bursts(bursts),
    .o_errs(merrs));

  task automatic complete_run();
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bail();
    fails++;
    complete_run();
  endtask
  task automatic chk(input logic [191:0] got, input logic [191:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  function automatic logic [WORD_W-1:0] wgen(input int i);
    return 48'hC3A5_0F00_1E2D ^ WORD_W'(i * 32'h0001_2345);
  endfunction
  task automatic boot(input logic [2:0] cfg, input logic [1:0] ty);
    rst = 1'b1;
    mcs = cfg;
    mts = ty;
    repeat (6) tick();
    rst = 1'b0;
    repeat (3) tick();
  endtask
  // Leaves valid high so consecutive words go back to back
  task automatic wr(input logic [WORD_W-1:0] d);
    int k;
    wv = 1'b1;
    wd = d;
    k = 0;
    while (o_wr_ready_s() !== 1'b1) begin
      tick();
      k++;
      if (k > 300) bail();
    end
    tick();
  endtask
  function automatic logic o_wr_ready_s();
    return wr_rdy;
  endfunction
  task automatic rd(input logic [WORD_W-1:0] e);
    int k;
    rr = 1'b1;
    k = 0;
    while (rd_v !== 1'b1) begin
      tick();
      k++;
      if (k > 300) bail();
    end
    chk(rd_d, e);
    tick();
  endtask
  task automatic wait_bursts(input int n);
    int k;
    k = 0;
    while (bursts < n) begin
      tick();
      k++;
      if (k > 300) bail();
    end
  endtask

  task automatic t_ecc_off();
    int b;
    boot(3'h7, 2'h3);
    chk(ecc, 1'b0);
    chk({cerr, full, empty}, 3'h1);
    b = bursts;
    for (int i = 0; i < 8; i++) wr(wgen(i));
    wv = 1'b0;
    wait_bursts(b + 2);
    chk(last, {wgen(7), wgen(6), wgen(5), wgen(4)});
    chk(empty, 1'b0);
    repeat (4) tick();
    for (int i = 0; i < 8; i++) rd(wgen(i));
    rr = 1'b0;
    tick();
    chk({empty, oe_n, dqs_oe_n}, 3'h7);
  endtask
  task automatic t_ecc_on();
    int b;
    int n;
    boot(3'h5, 2'h3);
    chk(ecc, 1'b1);
    flip = 1'b1;
    b = bursts;
    wr(wgen(20));
    wr(wgen(21));
    wv = 1'b0;
    wait_bursts(b + 1);
    chk({last[191:144], last[127:112], last[63:48]}, '0);
    chk({last[111:64], last[47:0]}, {wgen(21), wgen(20)});
    n = ncorr;
    rd(wgen(20));
    rd(wgen(21));
    flip = 1'b0;
    wr(wgen(22));
    wr(wgen(23));
    wv = 1'b0;
    rd(wgen(22));
    rd(wgen(23));
    rr = 1'b0;
    tick();
    chk(ncorr - n, 1);
  endtask
  task automatic t_bad_cfg();
    int b;
    boot(3'h0, 2'h3);
    chk(cerr, 1'b1);
    boot(3'h7, 2'h2);
    chk(cerr, 1'b1);
    b = bursts;
    for (int i = 0; i < FIFO_D; i++) wr(wgen(40 + i));
    chk(wr_rdy, 1'b0);
    wv = 1'b0;
    chk(bursts - b, 0);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    bail();
  end
  initial begin
    t_ecc_off();
    t_ecc_on();
    t_bad_cfg();
    chk(merrs, 0);
    complete_run();
  end
endmodule
`default_nettype wire
